// *** hw/rxq_readout_pkg.sv ***
`default_nettype none
package rxq_readout_pkg;
	// Register byte offsets on the APB port
	localparam logic [7:0] OFF_CTRL  = 8'h00; // rx_queue_control_reg
	localparam logic [7:0] OFF_PTR   = 8'h04; // rx_data_pointer_reg
	localparam logic [7:0] OFF_STAT  = 8'h08; // interrupt_status_reg
	localparam logic [7:0] OFF_CLR   = 8'h0C; // Write-only clear
	localparam logic [7:0] OFF_ENA   = 8'h10; // interrupt_enable_reg
	localparam logic [7:0] OFF_FCNT  = 8'h14; // rx_frame_count_reg
	localparam logic [7:0] OFF_HSTAT = 8'h18; // frame_header_status_reg
	localparam logic [7:0] OFF_HCNT  = 8'h1C; // frame_header_byte_count_reg
	localparam logic [7:0] OFF_DATA  = 8'h20; // Queue data window
	// Field positions
	localparam int CTRL_DMA_BIT = 3;
	localparam int CTRL_DEQ_BIT = 4;
	localparam int PTR_AUTO_BIT = 14;
	localparam int RX_INT_BIT   = 13;
	localparam int FCNT_LSB     = 8;
	localparam int PTR_W        = 11;
	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] PTR_RST  = 16'h0000;
	localparam logic [15:0] ENA_RST  = 16'h0000;
	localparam logic [31:0] SLVERR_DATA = 32'h0000_0000;

	// One queued frame header
	typedef struct packed {
		logic [15:0] status;
		logic [11:0] count;
	} hdr_entry_type;
endpackage
`default_nettype wire

// *** hw/rxq_readout.sv ***
// The APB register port and the placing of the registers were decided locally.
`default_nettype none
// Behaviour
// - first data read of each DMA burst returns a dummy byte or word.
// - writing one to receive interrupt bit clears it and loads frame count.
// - reading frame count loads header status and byte count of first frame.
// - after both header registers are read, load them with the next frame.
// - with control bit 4 set, frames dequeue automatically once read out.
// - receive interrupt is signalled only while enable bit 13 is set.
// - with pointer bit 14 set, pointer steps on each data read except the dummy read and a read that dequeues a frame, which clears it.
module rxq_readout
	import rxq_readout_pkg::*;
#(
	parameter int AW    = 9,  // Log2 of data words held
	parameter int HW    = 3,  // Log2 of frame headers held
	parameter bit BUS16 = 1'b1 // 1: 16-bit host bus, 0: 8-bit
) (
	input  wire logic          CORE_CLK_I,
	input  wire logic          RST_B_I,
	input  wire logic          PSEL_I,
	input  wire logic          PENABLE_I,
	input  wire logic          PWRITE_I,
	input  wire logic [7:0]    PADDR_I,
	input  wire logic [31:0]   PWDATA_I,
	output var  logic [31:0]   PRDATA_O,
	output var  logic          PREADY_O,
	output var  logic          PSLVERR_O,
	input  wire logic          FILL_VALID_I,
	input  wire logic [15:0]   FILL_DATA_I,
	input  wire logic          FILL_LAST_I,
	input  wire hdr_entry_type FILL_HDR_I,
	output var  logic          FILL_READY_O,
	output var  logic          IRQ_O
);
	localparam logic [PTR_W-1:0] STEP = PTR_W'(BUS16 ? 2 : 1);

	logic [15:0]         mem [2**AW];
	hdr_entry_type       hq [2**HW];
	logic [AW:0]         wr_q, base_q;
	logic [HW:0]         hw_q, hr_q, view_q;
	logic [15:0]         ctrl_q, ptrreg_q, ena_q, isr_q;
	logic [7:0]          rx_frame_count_reg_q;
	hdr_entry_type       hview_q;
	logic                rd_s_q, rd_c_q, dummy_q;
	logic [PTR_W-1:0]    ptr_q;

	logic                setup, acc, wr_acc, rd_acc, fill_go, frame_evt;
	logic                clear_hit, rd_data, rd_fcnt, both_done, deq_fire;
	logic [HW:0]         frames;
	logic [AW:0]         used;
	hdr_entry_type       head;
	logic [12:0]         pad;
	logic [PTR_W-1:0]    ptr_next;
	logic [15:0]         word;
	logic [31:0]         rdata;
	logic                mapped;

	// Bus decode; the slave never inserts wait states
	assign setup     = PSEL_I & ~PENABLE_I;
	assign acc       = PSEL_I & PENABLE_I;
	assign wr_acc    = acc & PWRITE_I;
	assign rd_acc    = acc & ~PWRITE_I;
	assign clear_hit = wr_acc & PWDATA_I[RX_INT_BIT]
		& (PADDR_I == OFF_STAT || PADDR_I == OFF_CLR);
	assign rd_data   = rd_acc & (PADDR_I == OFF_DATA);
	assign rd_fcnt   = rd_acc & (PADDR_I == OFF_FCNT);
	assign both_done = rd_acc
		& ((PADDR_I == OFF_HSTAT && rd_c_q) || (PADDR_I == OFF_HCNT && rd_s_q));

	// Queue occupancy
	assign frames    = hw_q - hr_q;
	assign used      = wr_q - base_q;
	assign head      = hq[hr_q[HW-1:0]];
	assign fill_go   = FILL_VALID_I & FILL_READY_O;
	assign frame_evt = fill_go & FILL_LAST_I;

	// Padded length of the head frame, rounded to a double word
	assign pad       = (13'(head.count) + 13'h3) & 13'h1FFC;
	assign ptr_next  = ptr_q + STEP;
	assign deq_fire  = rd_data & ~dummy_q & ctrl_q[CTRL_DEQ_BIT]
		& (frames != '0) & ({2'b00, ptr_next} >= pad);

	// Data word under the pointer; byte lane picked in 8-bit mode
	assign word = mem[AW'(base_q + (AW+1)'(ptr_q[PTR_W-1:1]))];

	// Read mux, evaluated in the setup phase
	always_comb
	begin
		mapped = 1'b1;
		rdata  = '0;
		case (PADDR_I)
			OFF_CTRL:  rdata[15:0] = ctrl_q;
			OFF_PTR:   rdata[15:0] = {ptrreg_q[15:PTR_W], ptr_q};
			OFF_STAT:  rdata[15:0] = isr_q;
			OFF_CLR:   rdata       = '0;
			OFF_ENA:   rdata[15:0] = ena_q;
			OFF_FCNT:  rdata[15:FCNT_LSB] = rx_frame_count_reg_q;
			OFF_HSTAT: rdata[15:0] = hview_q.status;
			OFF_HCNT:  rdata[11:0] = hview_q.count;
			OFF_DATA:
			begin
				if (dummy_q)
					rdata = '0;
				else if (BUS16)
					rdata[15:0] = word;
				else
					rdata[7:0] = ptr_q[0] ? word[15:8] : word[7:0];
			end
			default:   mapped = 1'b0;
		endcase
	end

	// APB answer; data is latched in setup so it is stable in access
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			PRDATA_O  <= '0;
			PREADY_O  <= 1'b0;
			PSLVERR_O <= 1'b0;
		end
		else
		begin
			PREADY_O <= 1'b1;
			if (setup)
			begin
				PRDATA_O  <= mapped ? rdata : SLVERR_DATA;
				PSLVERR_O <= ~mapped;
			end
		end
	end

	// Queue fill; frames start on double-word boundaries so padding
	// reads stay inside the frame's own slot
	always_ff @(posedge CORE_CLK_I)
	begin
		if (fill_go)
			mem[wr_q[AW-1:0]] <= FILL_DATA_I;
		if (frame_evt)
			hq[hw_q[HW-1:0]] <= FILL_HDR_I;
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			wr_q         <= '0;
			hw_q         <= '0;
			FILL_READY_O <= 1'b0;
		end
		else
		begin
			if (fill_go)
				wr_q <= (FILL_LAST_I && !wr_q[0])
					? wr_q + (AW+1)'(2) : wr_q + (AW+1)'(1);
			if (frame_evt)
				hw_q <= hw_q + 1'b1;
			// Margin of four words covers the registered ready
			FILL_READY_O <= (used < (AW+1)'(2**AW - 4))
				&& (frames < (HW+1)'(2**HW - 1));
		end
	end

	// Control and enable registers
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			ctrl_q <= CTRL_RST;
			ena_q  <= ENA_RST;
		end
		else if (wr_acc)
		begin
			if (PADDR_I == OFF_CTRL)
				ctrl_q <= PWDATA_I[15:0];
			if (PADDR_I == OFF_ENA)
				ena_q <= PWDATA_I[15:0];
		end
	end

	// Dummy read armed on each rising DMA start bit
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			dummy_q <= 1'b0;
		else if (wr_acc && PADDR_I == OFF_CTRL && PWDATA_I[CTRL_DMA_BIT]
			&& !ctrl_q[CTRL_DMA_BIT])
			dummy_q <= 1'b1;
		else if (rd_data)
			dummy_q <= 1'b0;
	end

	// Read pointer, auto increment and auto dequeue
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			ptrreg_q <= PTR_RST;
			ptr_q    <= '0;
			hr_q     <= '0;
			base_q   <= '0;
		end
		else if (deq_fire)
		begin
			ptr_q  <= '0;
			hr_q   <= hr_q + 1'b1;
			base_q <= base_q + (AW+1)'(pad[12:1]);
		end
		else if (wr_acc && PADDR_I == OFF_PTR)
		begin
			ptrreg_q <= PWDATA_I[15:0];
			ptr_q    <= PWDATA_I[PTR_W-1:0];
		end
		else if (rd_data && !dummy_q && ptrreg_q[PTR_AUTO_BIT])
			ptr_q <= ptr_next;
	end

	// Sticky status: a new frame wins over a clear in the same cycle
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			isr_q  <= '0;
			rx_frame_count_reg_q <= '0;
		end
		else
		begin
			if (frame_evt)
				isr_q[RX_INT_BIT] <= 1'b1;
			else if (clear_hit)
				isr_q[RX_INT_BIT] <= 1'b0;
			if (clear_hit)
				rx_frame_count_reg_q <= 8'(frames);
		end
	end

	// Interrupt line, gated by the enable bit
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(isr_q & ena_q);
	end

	// Header view: count read loads the head, paired reads step on.
	// Past the last queued frame the view reads zero.
	always_ff @(posedge CORE_CLK_I or negedge RST_B_I)
	begin
		if (!RST_B_I)
		begin
			view_q  <= '0;
			hview_q <= '0;
			rd_s_q  <= 1'b0;
			rd_c_q  <= 1'b0;
		end
		else if (rd_fcnt)
		begin
			view_q  <= hr_q;
			hview_q <= (frames != '0) ? head : '0;
			rd_s_q  <= 1'b0;
			rd_c_q  <= 1'b0;
		end
		else if (both_done)
		begin
			view_q  <= view_q + 1'b1;
			hview_q <= (view_q + 1'b1 != hw_q)
				? hq[HW'(view_q + 1'b1)] : '0;
			rd_s_q  <= 1'b0;
			rd_c_q  <= 1'b0;
		end
		else if (rd_acc && PADDR_I == OFF_HSTAT)
			rd_s_q <= 1'b1;
		else if (rd_acc && PADDR_I == OFF_HCNT)
			rd_c_q <= 1'b1;
	end

	// Checks
	property p_dummy;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		rd_data && dummy_q |-> PRDATA_O == '0 ##1 !dummy_q;
	endproperty
	a_dummy: assert property (p_dummy) else $error("dummy read bad");

	property p_clear;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		clear_hit && !frame_evt |=> !isr_q[RX_INT_BIT]
			&& rx_frame_count_reg_q == 8'($past(frames));
	endproperty
	a_clear: assert property (p_clear) else $error("clear bad");

	property p_fcnt;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		rd_fcnt && frames != '0 |=> view_q == $past(hr_q)
			&& hview_q == $past(head);
	endproperty
	a_fcnt: assert property (p_fcnt) else $error("header load bad");

	property p_next;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		both_done && !rd_fcnt |=> view_q == $past(view_q) + 1'b1
			&& !rd_s_q && !rd_c_q;
	endproperty
	a_next: assert property (p_next) else $error("next header bad");

	property p_deq;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		deq_fire |=> hr_q == $past(hr_q) + 1'b1 && ptr_q == '0;
	endproperty
	a_deq: assert property (p_deq) else $error("dequeue bad");

	property p_no_deq;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		!ctrl_q[CTRL_DEQ_BIT] |=> hr_q == $past(hr_q);
	endproperty
	a_no_deq: assert property (p_no_deq) else $error("dequeue off");

	property p_irq;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		!ena_q[RX_INT_BIT] ##1 !ena_q[RX_INT_BIT] |-> !IRQ_O;
	endproperty
	a_irq: assert property (p_irq) else $error("masked irq");

	property p_inc;
		@(posedge CORE_CLK_I) disable iff (!RST_B_I)
		rd_data && !dummy_q && ptrreg_q[PTR_AUTO_BIT] && !deq_fire
			|=> ptr_q == $past(ptr_q) + STEP;
	endproperty
	a_inc: assert property (p_inc) else $error("ptr step bad");

	c_dummy: cover property (@(posedge CORE_CLK_I) rd_data && dummy_q);
	c_deq:   cover property (@(posedge CORE_CLK_I) deq_fire);
	c_next:  cover property (@(posedge CORE_CLK_I) both_done);
	c_irq:   cover property (@(posedge CORE_CLK_I) IRQ_O);
endmodule // rxq_readout
`default_nettype wire

// *** tb/rxq_fill_model.sv ***
`default_nettype none
// Fabric-side frame source; holds each word until the block takes it
module rxq_fill_model
	import rxq_readout_pkg::*;
(
	input  wire logic          clk_i,
	input  wire logic          rst_b_i,
	input  wire logic          start_i,
	input  wire logic [3:0]    words_i,
	input  wire logic [15:0]   base_i,
	input  wire hdr_entry_type hdr_i,
	input  wire logic          ready_i,
	output var  logic          valid_o,
	output var  logic [15:0]   data_o,
	output var  logic          last_o,
	output var  hdr_entry_type hdr_o,
	output var  logic          busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] idx_q;

	// Idle data toggles so a stale word never passes for a fresh one
	always_ff @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			valid_o <= 1'b0;
			last_o  <= 1'b0;
			busy_o  <= 1'b0;
			idx_q   <= 4'h0;
			data_o  <= 16'h0000;
			hdr_o   <= '0;
		end
		else if (valid_o && ready_i)
		begin
			idx_q  <= idx_q + 4'h1;
			data_o <= base_i + {12'h000, idx_q} + 16'h0001;
			last_o <= (idx_q + 4'h2 == words_i);
			if (last_o)
			begin
				valid_o <= 1'b0;
				busy_o  <= 1'b0;
			end
		end
		else if (start_i && !busy_o)
		begin
			valid_o <= 1'b1;
			busy_o  <= 1'b1;
			idx_q   <= 4'h0;
			data_o  <= base_i;
			last_o  <= (words_i == 4'h1);
			hdr_o   <= hdr_i;
		end
		else if (!valid_o)
			data_o <= ~data_o;
	end
endmodule // rxq_fill_model
`default_nettype wire

// *** tb/rxq_readout_test.sv ***
`default_nettype none
module rxq_readout_test;
	import rxq_readout_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_type;
	logic          clk = 1'b0;
	logic          rst_b = 1'b0;
	logic          psel = 1'b0;
	logic          penable = 1'b0;
	logic          pwrite = 1'b0;
	logic [7:0]    paddr = 8'h00;
	logic [31:0]   pwdata = 32'h0;
	logic [31:0]   prdata, r;
	logic          pready, perr, e, fv, fl, fr, irq, busy;
	logic          start = 1'b0;
	logic [3:0]    words = 4'h1;
	logic [15:0]   base = 16'h0000;
	logic [15:0]   fd;
	hdr_entry_type hdr = '0;
	hdr_entry_type fh;
	int            mismatches = 0;
	int            cmp_count = 0;
	row_type       rows[6];

	rxq_readout dut_u (.CORE_CLK_I(clk), .RST_B_I(rst_b), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
		.PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
		.PSLVERR_O(perr), .FILL_VALID_I(fv), .FILL_DATA_I(fd),
		.FILL_LAST_I(fl), .FILL_HDR_I(fh), .FILL_READY_O(fr), .IRQ_O(irq));
	rxq_fill_model fill_u (.clk_i(clk), .rst_b_i(rst_b), .start_i(start),
		.words_i(words), .base_i(base), .hdr_i(hdr), .ready_i(fr),
		.valid_o(fv), .data_o(fd), .last_o(fl), .hdr_o(fh), .busy_o(busy));

	// 20 MHz core clock
	always #25 clk = ~clk;

	task automatic give_verdict();
		$display("mismatches %0d compares %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x)
		begin
			mismatches++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, x);
		end
	endtask

	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask

	// Flag checked after two edges so its update has landed
	task automatic flag(input logic x);
		repeat (2) @(posedge clk);
		#1 chk({31'h0, irq}, {31'h0, x});
	endtask

	task automatic send(input logic [3:0] n, input logic [15:0] b,
		input hdr_entry_type h);
		@(posedge clk);
		words <= n;
		base  <= b;
		hdr   <= h;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (40)
		begin
			@(posedge clk);
			if (busy === 1'b0)
				break;
		end
	endtask

	// Watchdog: the whole run needs well under 1000 cycles
	initial
	begin
		#(4000 * 50);
		mismatches++;
		give_verdict();
	end

	initial
	begin
		rows[0] = '{OFF_CTRL, {16'h0, CTRL_RST}, 1'b0};
		rows[1] = '{OFF_PTR, {16'h0, PTR_RST}, 1'b0};
		rows[2] = '{OFF_ENA, {16'h0, ENA_RST}, 1'b0};
		rows[3] = '{OFF_STAT, 32'h0, 1'b0};
		rows[4] = '{OFF_CLR, 32'h0, 1'b0};
		rows[5] = '{8'h40, SLVERR_DATA, 1'b1};
		repeat (12) @(posedge clk);
		chk({31'h0, pready}, 32'h0);
		rst_b <= 1'b1;
		foreach (rows[i])
		begin
			rd(rows[i].a, rows[i].d);
			chk({31'h0, e}, {31'h0, rows[i].e});
		end
		send(4'h3, 16'h1100, '{16'h8001, 12'd6});
		send(4'h2, 16'h2200, '{16'h8002, 12'd4});
		rd(OFF_STAT, 32'h0000_2000);
		flag(1'b0);
		apb(1'b1, OFF_ENA, 32'h0000_2000);
		flag(1'b1);
		apb(1'b1, OFF_STAT, 32'h0000_2000);
		rd(OFF_STAT, 32'h0);
		flag(1'b0);
		rd(OFF_FCNT, 32'h0000_0200);
		rd(OFF_HSTAT, 32'h0000_8001);
		rd(OFF_HCNT, 32'h0000_0006);
		rd(OFF_HCNT, 32'h0000_0004);
		rd(OFF_HSTAT, 32'h0000_8002);
		apb(1'b1, OFF_PTR, 32'h0000_4000);
		apb(1'b1, OFF_CTRL, 32'h0000_0018);
		rd(OFF_DATA, 32'h0);
		for (int i = 0; i < 3; i++)
			rd(OFF_DATA, 32'h0000_1100 + i);
		apb(1'b0, OFF_DATA, 32'h0);
		rd(OFF_PTR, 32'h0000_4000);
		chk({31'h0, fr}, 32'h1);
		send(4'h1, 16'h3300, '{16'h8003, 12'd2});
		apb(1'b1, OFF_CLR, 32'h0000_2000);
		rd(OFF_STAT, 32'h0);
		rd(OFF_FCNT, 32'h0000_0200);
		rd(OFF_HSTAT, 32'h0000_8002);
		give_verdict();
	end
endmodule // rxq_readout_test
`default_nettype wire
